// >>> plss_pkg.sv
// Package with register map, field positions and reset values of the link status block.
// Functional notes
// - The combined status register sits at management address 0x0010 with bits 15 down to 0.
// - The jabber bit reads 1 when jabber is detected and only means something at 10 Mb/s.
// - The jabber bit always equals the jabber bit of the basic mode status register.
// - Reading the combined status register clears neither the jabber bit nor the link bit.
// - Bit 4 reads 1 once auto-negotiation is complete and 0 before that.
// - Bit 3 reads 1 while MII loopback is enabled and active, otherwise 0.
// - Bit 2 reads 1 for full duplex and 0 for half duplex.
// - Duplex comes from the negotiation result when negotiating, else from the forced setting.
// - Bit 0 reads 1 with a valid link at 10 or 100 Mb/s and 0 without a link.
// - The link bit always equals the link bit of the basic mode status register.
`default_nettype none
package plss_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Management register numbers; the byte address is four times the number.
  localparam logic [7:0] BASIC_MODE_STATUS_REG_IDX = 8'h01;
  localparam logic [7:0] LINK_STATUS_SUMMARY_IDX = 8'h10;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_ENABLE_IDX = 8'h21;
  localparam logic [7:0] IRQ_CLEAR_IDX = 8'h22;
  // Field positions in the combined status register.
  localparam int BIT_LINK = 0;
  localparam int BIT_SPEED10 = 1;
  localparam int BIT_FULL_DUPLEX = 2;
  localparam int BIT_LOOPBACK = 3;
  localparam int BIT_AN_DONE = 4;
  localparam int BIT_JABBER = 5;
  // Field positions in the basic mode status register.
  localparam int BMS_BIT_LINK = 2;
  localparam int BMS_BIT_JABBER = 1;
  localparam int BMS_BIT_AN_DONE = 5;
  localparam int IRQ_W = 6;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    PLSS_IDLE = 2'b00,
    PLSS_RESP = 2'b01
  } plss_bus_state_type;
endpackage : plss_pkg
`default_nettype wire

// >>> plss_stat_if.sv
// Interface carrying the sampled status bits from the tracker to the register bank.
`default_nettype none
interface plss_stat_if;
  logic [5:0] status;
  modport producer (output status);
  modport consumer (input status);
endinterface : plss_stat_if
`default_nettype wire

// >>> plss_status_track.sv
// Status tracker that resolves and registers the link summary bits.
`default_nettype none
module plss_status_track
  import plss_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_link_valid,
  input wire logic i_jabber_detect,
  input wire logic i_an_enable,
  input wire logic i_an_complete,
  input wire logic i_an_full_duplex,
  input wire logic i_an_speed10,
  input wire logic i_forced_full_duplex,
  input wire logic i_forced_speed10,
  input wire logic i_loopback_enable,
  input wire logic i_loopback_active,
  plss_stat_if.producer stat
);
  logic [5:0] status_ff;
  logic [5:0] nxt_status;

  always_comb begin
    nxt_status = STATUS_RESET[5:0];
    nxt_status[BIT_LINK] = i_link_valid;
    nxt_status[BIT_JABBER] = i_jabber_detect;
    nxt_status[BIT_AN_DONE] = i_an_enable & i_an_complete;
    nxt_status[BIT_LOOPBACK] = i_loopback_enable & i_loopback_active;
    // Resolved from negotiation only when it runs, else the forced strap values apply.
    nxt_status[BIT_FULL_DUPLEX] = i_an_enable ? i_an_full_duplex
                                              : i_forced_full_duplex;
    nxt_status[BIT_SPEED10] = i_an_enable ? i_an_speed10 : i_forced_speed10;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status_ff <= STATUS_RESET[5:0];
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign stat.status = status_ff;
endmodule : plss_status_track
`default_nettype wire

// >>> plss_link_status.sv
// Top of the link status summary block with its Avalon-MM register bank.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`default_nettype none
module plss_link_status
  import plss_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [plss_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [plss_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [plss_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_link_valid,
  input wire logic i_jabber_detect,
  input wire logic i_an_enable,
  input wire logic i_an_complete,
  input wire logic i_an_full_duplex,
  input wire logic i_an_speed10,
  input wire logic i_forced_full_duplex,
  input wire logic i_forced_speed10,
  input wire logic i_loopback_enable,
  input wire logic i_loopback_active,
  output logic o_irq
);
  plss_stat_if stat_bus ();
  plss_bus_state_type state_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [IRQ_W-1:0] prev_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_en_ff;
  logic [5:0] st;
  logic [15:0] summary;
  logic [15:0] bms;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;
  logic req;
  logic wr_clear;
  logic wr_enable;
  logic rd_take;
  logic wr_take;
  logic [7:0] acc_idx;
  logic hit_summary;
  logic hit_bms;
  logic hit_irq_stat;
  logic hit_irq_en;
  logic hit_irq_clr;
  logic fld_link;
  logic fld_speed10;
  logic fld_full_duplex;
  logic fld_loopback;
  logic fld_an_done;
  logic fld_jabber;
  logic [IRQ_W-1:0] ev_rise;
  logic [IRQ_W-1:0] ev_fall;

  plss_status_track u_track (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_link_valid(i_link_valid),
    .i_jabber_detect(i_jabber_detect),
    .i_an_enable(i_an_enable),
    .i_an_complete(i_an_complete),
    .i_an_full_duplex(i_an_full_duplex),
    .i_an_speed10(i_an_speed10),
    .i_forced_full_duplex(i_forced_full_duplex),
    .i_forced_speed10(i_forced_speed10),
    .i_loopback_enable(i_loopback_enable),
    .i_loopback_active(i_loopback_active),
    .stat(stat_bus.producer)
  );

  assign st = stat_bus.status;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = {2'b00, addr[ADDR_W-1:2]};
  endfunction

  // Zero-extends a 16-bit register image onto the data bus.
  function automatic logic [DATA_W-1:0] widen16(input logic [15:0] img);
    widen16 = {{(DATA_W-16){1'b0}}, img};
  endfunction

  // Zero-extends an interrupt vector onto the data bus.
  function automatic logic [DATA_W-1:0] widen_irq(input logic [IRQ_W-1:0] vec);
    widen_irq = {{(DATA_W-IRQ_W){1'b0}}, vec};
  endfunction

  // Every writable field lives in byte lane 0, so a write without that lane changes nothing.
  function automatic logic lane0_write(input logic take, input logic [3:0] be);
    lane0_write = take & be[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register images. Both views are built from the same flops so they can never disagree.
  assign fld_link = st[BIT_LINK];
  assign fld_speed10 = st[BIT_SPEED10];
  assign fld_full_duplex = st[BIT_FULL_DUPLEX];
  assign fld_loopback = st[BIT_LOOPBACK];
  assign fld_an_done = st[BIT_AN_DONE];
  assign fld_jabber = st[BIT_JABBER];

  always_comb begin
    summary = STATUS_RESET;
    summary[BIT_LINK] = fld_link;
    summary[BIT_SPEED10] = fld_speed10;
    summary[BIT_FULL_DUPLEX] = fld_full_duplex;
    summary[BIT_LOOPBACK] = fld_loopback;
    summary[BIT_AN_DONE] = fld_an_done;
    summary[BIT_JABBER] = fld_jabber;
  end

  // Only the mirrored bits of the basic mode status image are kept here; the rest read 0.
  always_comb begin
    bms = 16'h0000;
    bms[BMS_BIT_LINK] = fld_link;
    bms[BMS_BIT_JABBER] = fld_jabber;
    bms[BMS_BIT_AN_DONE] = fld_an_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access takes one wait cycle, then answers.
  assign req = (i_avs_read | i_avs_write) && (state_ff == PLSS_IDLE);
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) && (state_ff != PLSS_RESP);
  assign rd_take = req & i_avs_read;
  assign wr_take = req & i_avs_write;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the read path and both writable registers.
  assign acc_idx = reg_index(i_avs_address);
  assign hit_summary = (acc_idx == LINK_STATUS_SUMMARY_IDX);
  assign hit_bms = (acc_idx == BASIC_MODE_STATUS_REG_IDX);
  assign hit_irq_stat = (acc_idx == IRQ_STATUS_IDX);
  assign hit_irq_en = (acc_idx == IRQ_ENABLE_IDX);
  assign hit_irq_clr = (acc_idx == IRQ_CLEAR_IDX);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_ff <= PLSS_IDLE;
    end else begin
      case (state_ff)
        PLSS_IDLE: begin
          if (req) begin
            state_ff <= PLSS_RESP;
          end
        end
        PLSS_RESP: begin
          state_ff <= PLSS_IDLE;
        end
        default: begin
          state_ff <= PLSS_IDLE;
        end
      endcase
    end
  end

  // Reads have no side effect on any status bit.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= UNMAPPED_READ;
    end else if (rd_take) begin
      if (hit_summary) begin
        rdata_ff <= widen16(summary);
      end else if (hit_bms) begin
        rdata_ff <= widen16(bms);
      end else if (hit_irq_stat) begin
        rdata_ff <= widen_irq(irq_stat_ff);
      end else if (hit_irq_en) begin
        rdata_ff <= widen_irq(irq_en_ff);
      end else begin
        rdata_ff <= UNMAPPED_READ;
      end
    end
  end

  assign o_avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts on any change of a status bit. Writes to the status images are dropped.
  assign wr_clear = lane0_write(wr_take, i_avs_byteenable) & hit_irq_clr;
  assign wr_enable = lane0_write(wr_take, i_avs_byteenable) & hit_irq_en;
  assign clr = wr_clear ? i_avs_writedata[IRQ_W-1:0] : {IRQ_W{1'b0}};
  // Both directions count, so a lost link raises the same flag as a new one.
  assign ev_rise = st & ~prev_ff;
  assign ev_fall = ~st & prev_ff;
  assign events = ev_rise | ev_fall;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prev_ff <= STATUS_RESET[5:0];
    end else begin
      prev_ff <= st;
    end
  end

  // A new event in the clear cycle survives, since set is ordered after clear.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_stat_ff <= {IRQ_W{1'b0}};
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr) | events;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      irq_en_ff <= {IRQ_W{1'b0}};
    end else if (wr_enable) begin
      irq_en_ff <= i_avs_writedata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_stat_ff & irq_en_ff);
endmodule : plss_link_status
`default_nettype wire

// >>> plss_mgmt.sv
// Management controller model that masters the register bus.
`default_nettype none
module plss_mgmt (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_wait,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h0;
  end
  // Call just after a rising edge; the request stands until waitrequest is sampled low.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    o_addr <= a;
    o_wr <= w;
    o_rd <= !w;
    o_wdata <= d;
    do @(posedge i_sys_clk); while (i_wait !== 1'b0);
    q = i_rdata;
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
endmodule // plss_mgmt
`default_nettype wire

// >>> plss_link_status_chk.sv
// Port checker for the link status block.
`default_nettype none
module plss_link_status_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [plss_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [plss_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_link_valid,
  input wire logic i_jabber_detect,
  input wire logic i_an_enable,
  input wire logic i_an_complete,
  input wire logic i_an_full_duplex,
  input wire logic i_an_speed10,
  input wire logic i_forced_full_duplex,
  input wire logic i_forced_speed10,
  input wire logic i_loopback_enable,
  input wire logic i_loopback_active,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import plss_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire rs = i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h40;
  wire an_d = i_an_enable & i_an_complete;
  wire lb = i_loopback_enable & i_loopback_active;
  wire fd = i_an_enable ? i_an_full_duplex : i_forced_full_duplex;
  wire sp = i_an_enable ? i_an_speed10 : i_forced_speed10;
  a_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("waitrequest held too long");
  a_link_bit: assert property (rs |-> o_avs_readdata[0] == $past(i_link_valid, 2))
    else $error("link bit wrong");
  a_jabber_bit: assert property (rs |-> o_avs_readdata[5] == $past(i_jabber_detect, 2))
    else $error("jabber bit wrong");
  a_an_done: assert property (rs |-> o_avs_readdata[4] == $past(an_d, 2))
    else $error("negotiation bit wrong");
  a_loop_bit: assert property (rs |-> o_avs_readdata[3] == $past(lb, 2))
    else $error("loopback bit wrong");
  a_duplex_bit: assert property (rs |-> o_avs_readdata[2] == $past(fd, 2))
    else $error("duplex bit wrong");
  a_speed_bit: assert property (rs |-> o_avs_readdata[1] == $past(sp, 2))
    else $error("speed bit wrong");
  a_high_zero: assert property (rs |-> o_avs_readdata[31:6] == 26'h0)
    else $error("upper bits not zero");
  c_link_up: cover property (rs && o_avs_readdata[0]);
  c_irq: cover property (o_irq);
  c_write: cover property (i_avs_write && !o_avs_waitrequest);
endmodule // plss_link_status_chk
`default_nettype wire

// >>> plss_link_status_tb.sv
// Self-checking testbench for the link status block.
`default_nettype none
module plss_link_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import plss_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] ph = 10'h000;
  logic [7:0] addr;
  logic rd, wr, wq, irq;
  logic [31:0] wd, rdata, q;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  plss_mgmt i_plss_mgmt (.i_sys_clk(clk), .i_rdata(rdata), .i_wait(wq), .o_addr(addr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wd));
  plss_link_status i_plss_link_status (.i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_link_valid(ph[0]),
    .i_jabber_detect(ph[1]), .i_an_enable(ph[2]), .i_an_complete(ph[3]),
    .i_an_full_duplex(ph[4]), .i_an_speed10(ph[5]), .i_forced_full_duplex(ph[6]),
    .i_forced_speed10(ph[7]), .i_loopback_enable(ph[8]), .i_loopback_active(ph[9]), .o_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    i_plss_mgmt.xfer(w, a, d, q);
  endtask
  // Duplex and speed are compared even without a link, stricter than software needs.
  function automatic logic [31:0] summ(input logic [9:0] p);
    return {26'h0, p[1], p[2] & p[3], p[8] & p[9], p[2] ? p[4] : p[6], p[2] ? p[5] : p[7], p[0]};
  endfunction
  task automatic t_bits;
    logic [9:0] pats [7] = '{10'h001, 10'h3FF, 10'h0D5, 10'h12E, 10'h23B, 10'h0C1, 10'h000};
    foreach (pats[k]) begin
      @(posedge clk);
      ph <= pats[k];
      repeat (2) @(posedge clk);
      acc(1'b0, 8'h40, 32'h0);
      chk(q, summ(pats[k]));
      acc(1'b0, 8'h40, 32'h0);
      chk(q, summ(pats[k]));
      acc(1'b0, 8'h04, 32'h0);
      chk(q & 32'h6, {29'h0, pats[k][0], pats[k][1], 1'b0});
    end
    $display("test bits done");
  endtask
  task automatic t_wr;
    acc(1'b1, 8'h40, 32'hFFFF);
    acc(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    $display("test write done");
  endtask
  task automatic t_irq;
    acc(1'b1, 8'h88, 32'h3F);
    acc(1'b1, 8'h84, 32'h3F);
    ph <= 10'h001;
    repeat (3) @(negedge clk);
    chk(32'(irq), 32'h1);
    acc(1'b0, 8'h80, 32'h0);
    chk(q, 32'h1);
    acc(1'b1, 8'h84, 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    acc(1'b1, 8'h84, 32'h1);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    acc(1'b1, 8'h88, 32'h1);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    $display("test irq done");
  endtask
  // Reset in mid-run with every input high: the registers must drop to 0 and recover.
  task automatic t_rst;
    @(posedge clk);
    ph <= 10'h3FF;
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk(rdata, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(wq), 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h40, 32'h0);
    chk(q, summ(10'h3FF));
    $display("test reset done");
  endtask
  task automatic end_sim;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    acc(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    t_bits;
    t_wr;
    t_irq;
    t_rst;
    end_sim;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_sim;
    end
  end
endmodule // plss_link_status_tb
bind plss_link_status plss_link_status_chk i_plss_link_status_chk (.i_sys_clk, .i_rst_n,
  .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_link_valid,
  .i_jabber_detect, .i_an_enable, .i_an_complete, .i_an_full_duplex, .i_an_speed10,
  .i_forced_full_duplex, .i_forced_speed10, .i_loopback_enable, .i_loopback_active, .o_irq);
`default_nettype wire
